// [bench/dsp_core_test.sv]
// Purpose: self-checking bench for the memory port
// Assumes: small address width for speed
// Notes:   reads checked 110 ns after the launching link edge
`timescale 1ns/1ps
`include "dsp_defs.svh"
module dsp_core_test;
    localparam int DW = 36;
    localparam int AW = 6;
    localparam int LN = DW/`DSP_LANE_W;
    localparam logic [DW-1:0] A0 = 36'h1_2345_6789;
    localparam logic [DW-1:0] A1 = 36'hA_BCDE_F012;
    localparam logic [DW-1:0] B0 = 36'h5_5AA5_3CC3;
    localparam logic [DW-1:0] B1 = 36'h0_F0F0_0F0F;
    localparam logic [DW-1:0] C0 = 36'h9_8765_4321;
    localparam logic [DW-1:0] C1 = 36'hF_FFFF_FFFF;
    logic          core_clk = 1'b0;
    logic          rstn = 1'b0;
    logic          link_k, link_k_n, cmd_load_n, read_not_write;
    logic          dq_oe_n, read_valid_flag, echo_timing_p, echo_timing_n;
    logic [AW-1:0] addr;
    logic [LN-1:0] byte_lane_select_n;
    logic [DW-1:0] dq_in, dq_out;
    int            errors = 0;
    int            num_checks = 0;

    always #10 core_clk = ~core_clk;

    dsp_core #(.DATA_W(DW), .ADDR_W(AW)) i_dsp_core (
        .core_clk(core_clk), .rstn(rstn), .link_k(link_k),
        .link_k_n(link_k_n), .addr(addr), .cmd_load_n(cmd_load_n),
        .read_not_write(read_not_write),
        .byte_lane_select_n(byte_lane_select_n), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .read_valid_flag(read_valid_flag),
        .echo_timing_p(echo_timing_p), .echo_timing_n(echo_timing_n));

    dsp_ctrl_model #(.DATA_W(DW), .ADDR_W(AW)) i_dsp_ctrl_model (
        .link_k(link_k), .link_k_n(link_k_n), .addr(addr),
        .cmd_load_n(cmd_load_n), .read_not_write(read_not_write),
        .byte_lane_select_n(byte_lane_select_n), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n));

    // =================================================================
    // checking helpers
    task automatic chk(input string what, input logic [DW-1:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report;
        if (errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, n,
                                            input logic [LN-1:0] s);
        merge = o;
        for (int i = 0; i < LN; i++) begin
            if (!s[i]) merge[i*9 +: 9] = n[i*9 +: 9];
        end
    endfunction

    task automatic rd_check(input logic [AW-1:0] a,
                            input logic [DW-1:0] e0, e1);
        i_dsp_ctrl_model.read_cmd(a);
        repeat (3) @(posedge link_k_n);
        @(posedge link_k) #30;
        chk("word0", dq_out, e0);
        chk("oe_n", DW'(dq_oe_n), '0);
        chk("valid", DW'(read_valid_flag), DW'(1'b1));
        chk("echo_p", DW'(echo_timing_p), '0);
        chk("echo_n", DW'(echo_timing_n), DW'(1'b1));
        @(posedge link_k_n) #30;
        chk("word1", dq_out, e1);
        chk("valid", DW'(read_valid_flag), DW'(1'b1));
        chk("echo_p", DW'(echo_timing_p), DW'(1'b1));
        chk("echo_n", DW'(echo_timing_n), '0);
        @(posedge link_k) #30;
        chk("oe_n", DW'(dq_oe_n), DW'(1'b1));
        chk("valid", DW'(read_valid_flag), '0);
    endtask

    // =================================================================
    // scenarios
    task automatic t_reset;
        chk("oe_n", DW'(dq_oe_n), DW'(1'b1));
        chk("valid", DW'(read_valid_flag), '0);
    endtask

    task automatic t_two_bursts;
        i_dsp_ctrl_model.write_burst(6'h05, A0, A1, '0, '0);
        i_dsp_ctrl_model.write_burst(6'h06, B0, B1, '0, '0);
        rd_check(6'h05, A0, A1);
        rd_check(6'h06, B0, B1);
    endtask

    task automatic t_mask;
        i_dsp_ctrl_model.write_burst(6'h05, C0, C1, 4'b1010, 4'b0101);
        rd_check(6'h05, merge(A0, C0, 4'b1010),
                 merge(A1, C1, 4'b0101));
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        t_reset();
        #2 rstn = 1'b1;
        repeat (4) @(posedge core_clk);
        t_two_bursts();
        t_mask();
        final_report();
    end

    initial begin
        #100000;
        errors++;
        final_report();
    end
endmodule

// [bench/dsp_ctrl_model.sv]
// Purpose: memory controller driving link clocks, commands and data
// Assumes: free running link clock of 160 ns
// Notes:   bus level resolved here from both enables
`timescale 1ns/1ps
`include "dsp_defs.svh"
module dsp_ctrl_model #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 6
) (
    output logic                          link_k,
    output logic                          link_k_n,
    output logic [ADDR_W-1:0]             addr,
    output logic                          cmd_load_n,
    output logic                          read_not_write,
    output logic [DATA_W/`DSP_LANE_W-1:0] byte_lane_select_n,
    output logic [DATA_W-1:0]             dq_in,
    input  wire logic [DATA_W-1:0]        dq_out,
    input  wire logic                     dq_oe_n
);
    localparam int LN = DATA_W/`DSP_LANE_W;
    logic              drv_en;
    logic [DATA_W-1:0] drv_val;
    logic [DATA_W-1:0] idle_pat;

    assign link_k_n = ~link_k;
    // shared bus: device, controller or a changing float pattern
    assign dq_in = !dq_oe_n ? dq_out : (drv_en ? drv_val : idle_pat);

    always @(posedge link_k or posedge link_k_n) begin
        idle_pat <= ~idle_pat;
    end

    initial begin
        link_k = 1'b0;
        drv_en = 1'b0;
        drv_val = '0;
        idle_pat = '0;
        addr = '0;
        cmd_load_n = 1'b1;
        read_not_write = 1'b1;
        byte_lane_select_n = '1;
        #12;
        forever #80 link_k = ~link_k;
    end

    task automatic write_burst(input logic [ADDR_W-1:0] a,
                               input logic [DATA_W-1:0] w0, w1,
                               input logic [LN-1:0] s0, s1);
        @(negedge link_k);
        addr = a;
        cmd_load_n = 1'b0;
        read_not_write = 1'b0;
        @(negedge link_k);
        cmd_load_n = 1'b1;
        drv_en = 1'b1;
        drv_val = w0;
        byte_lane_select_n = s0;
        @(posedge link_k) #40;
        drv_val = w1;
        byte_lane_select_n = s1;
        @(posedge link_k_n) #40;
        drv_en = 1'b0;
        byte_lane_select_n = '1;
        addr = ~a;
    endtask

    task automatic read_cmd(input logic [ADDR_W-1:0] a);
        @(negedge link_k);
        addr = a;
        cmd_load_n = 1'b0;
        read_not_write = 1'b1;
        @(posedge link_k) #40;
        cmd_load_n = 1'b1;
        addr = ~a;
    endtask
endmodule

// [bench/dsp_monitor.sv]
// Purpose: pin-level assertions for the memory port
// Assumes: link clocks are far slower than core_clk
// Notes:   bound to dsp_core below
`timescale 1ns/1ps
`include "dsp_defs.svh"
module dsp_monitor #(
    parameter int DATA_W = `DSP_DATA_W,
    parameter int ADDR_W = `DSP_ADDR_W
) (
    input wire logic                          core_clk,
    input wire logic                          rstn,
    input wire logic                          link_k,
    input wire logic                          link_k_n,
    input wire logic [ADDR_W-1:0]             addr,
    input wire logic                          cmd_load_n,
    input wire logic                          read_not_write,
    input wire logic [DATA_W/`DSP_LANE_W-1:0] byte_lane_select_n,
    input wire logic [DATA_W-1:0]             dq_in,
    input wire logic [DATA_W-1:0]             dq_out,
    input wire logic                          dq_oe_n,
    input wire logic                          read_valid_flag,
    input wire logic                          echo_timing_p,
    input wire logic                          echo_timing_n
);
    logic       k_d_ff;
    logic [5:0] idle_ff;
    logic [2:0] up_ff;

    // =================================================================
    // cycles since the last read command and since reset
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            k_d_ff <= 1'b1;
            idle_ff <= '0;
            up_ff <= '0;
        end else begin
            k_d_ff <= link_k;
            if (link_k && !k_d_ff && !cmd_load_n && read_not_write) begin
                idle_ff <= '0;
            end else begin
                idle_ff <= idle_ff + 6'(idle_ff != 6'h3f);
            end
            up_ff <= up_ff + 3'(up_ff != 3'h7);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // =================================================================
    // assertions
    a_valid_oe: assert property (read_valid_flag == !dq_oe_n)
        else $error("valid flag differs from bus drive");
    a_echo_p: assert property (
        $rose(link_k) |-> ##[1:5] $rose(echo_timing_p))
        else $error("true echo missing");
    a_echo_n: assert property (
        $rose(link_k_n) |-> ##[1:5] $rose(echo_timing_n))
        else $error("complement echo missing");
    a_read_latency: assert property (
        $rose(link_k) && !cmd_load_n && read_not_write
        |-> ##[19:25] !dq_oe_n) else $error("read data late or early");
    a_burst_len: assert property ($fell(dq_oe_n) |-> !dq_oe_n [*7])
        else $error("burst shorter than two words");
    a_word_hold: assert property (
        $rose(read_valid_flag) |=> $stable(dq_out) [*2])
        else $error("first word not held");
    a_idle_quiet: assert property (idle_ff >= 6'h28 |-> dq_oe_n)
        else $error("bus driven without read");
    a_echo_pair: assert property (
        up_ff == 3'h7 |-> echo_timing_p != echo_timing_n)
        else $error("echo clocks not complementary");

    c_read: cover property ($fell(dq_oe_n));
    c_write: cover property ($rose(link_k) && !cmd_load_n && !read_not_write);
    c_idle: cover property (idle_ff == 6'h3f);
endmodule

bind dsp_core dsp_monitor #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) i_dsp_monitor (
    .core_clk(core_clk), .rstn(rstn), .link_k(link_k), .link_k_n(link_k_n),
    .addr(addr), .cmd_load_n(cmd_load_n), .read_not_write(read_not_write),
    .byte_lane_select_n(byte_lane_select_n), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .read_valid_flag(read_valid_flag),
    .echo_timing_p(echo_timing_p), .echo_timing_n(echo_timing_n));

// [src/dsp_core.sv]
// Purpose: device-side logic of a ddr burst-of-two common-io sram port
// Assumes: link clocks are slow versus core_clk and are sampled by it
// Notes:   memory contents are not reset
`timescale 1ns/1ps
`include "dsp_defs.svh"

module dsp_core
    import dsp_pkg::*;
#(
    parameter int DATA_W = `DSP_DATA_W,
    parameter int ADDR_W = `DSP_ADDR_W
) (
    input  wire logic                           core_clk,
    input  wire logic                           rstn,
    input  wire logic                           link_k,
    input  wire logic                           link_k_n,
    input  wire logic [ADDR_W-1:0]              addr,
    input  wire logic                           cmd_load_n,
    input  wire logic                           read_not_write,
    input  wire logic [DATA_W/`DSP_LANE_W-1:0]  byte_lane_select_n,
    input  wire logic [DATA_W-1:0]              dq_in,
    output logic      [DATA_W-1:0]              dq_out,
    output logic                                dq_oe_n,
    output logic                                read_valid_flag,
    output logic                                echo_timing_p,
    output logic                                echo_timing_n
);

    // =================================================================
    // sizes
    localparam int LANES  = DATA_W / `DSP_LANE_W;
    localparam int SYNC_W = 4 + ADDR_W + LANES + DATA_W;
    localparam int DEPTH  = 2 ** (ADDR_W + 1);
    localparam int LAST   = `DSP_RD_STAGES - 1;

    // =================================================================
    // input synchroniser, two flops on every pin
    logic [SYNC_W-1:0]  sync1_ff;
    logic [SYNC_W-1:0]  sync2_ff;
    logic               k_prev_ff;
    logic               kn_prev_ff;
    wire  [SYNC_W-1:0]  pins_raw;

    assign pins_raw = {link_k, link_k_n, cmd_load_n, read_not_write,
                       addr, byte_lane_select_n, dq_in};

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= pins_raw;
            sync2_ff <= sync1_ff;
        end
    end

    wire                k_s;
    wire                kn_s;
    wire                load_n_s;
    wire                rd_not_wr_s;
    wire [ADDR_W-1:0]   addr_s;
    wire [LANES-1:0]    bsel_n_s;
    wire [DATA_W-1:0]   din_s;

    assign {k_s, kn_s, load_n_s, rd_not_wr_s,
            addr_s, bsel_n_s, din_s} = sync2_ff;

    // =================================================================
    // link clock edge detection
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            k_prev_ff  <= `DSP_BIT_RST;
            kn_prev_ff <= `DSP_BIT_RST;
        end else begin
            k_prev_ff  <= k_s;
            kn_prev_ff <= kn_s;
        end
    end

    wire k_rise;
    wire kn_rise;

    assign k_rise  = k_s & ~k_prev_ff;
    assign kn_rise = kn_s & ~kn_prev_ff;

    // =================================================================
    // command decode on the true clock rising edge
    wire rd_cmd;
    wire wr_cmd;

    assign rd_cmd = k_rise & ~load_n_s & rd_not_wr_s;
    assign wr_cmd = k_rise & ~load_n_s & ~rd_not_wr_s;

    // =================================================================
    // storage array, two words per burst address
    logic [DATA_W-1:0] mem [DEPTH];

    // =================================================================
    // write buffer: command, first word, second word then commit
    logic               wr_pend_ff;
    logic [ADDR_W-1:0]  wr_cmd_addr_ff;
    logic               wr_act_ff;
    logic [ADDR_W-1:0]  wr_act_addr_ff;
    logic [DATA_W-1:0]  wr_word0_ff;
    logic [LANES-1:0]   wr_bsel0_n_ff;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_ff     <= `DSP_BIT_RST;
            wr_cmd_addr_ff <= '0;
        end else if (k_rise) begin
            wr_pend_ff     <= wr_cmd;
            wr_cmd_addr_ff <= addr_s;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_act_ff      <= `DSP_BIT_RST;
            wr_act_addr_ff <= '0;
            wr_word0_ff    <= '0;
            wr_bsel0_n_ff  <= '0;
        end else if (k_rise) begin
            wr_act_ff      <= wr_pend_ff;
            wr_act_addr_ff <= wr_cmd_addr_ff;
            wr_word0_ff    <= din_s;
            wr_bsel0_n_ff  <= bsel_n_s;
        end else if (kn_rise) begin
            wr_act_ff      <= `DSP_BIT_RST;
        end
    end

    wire               commit;
    wire [ADDR_W:0]    wr_idx0;
    wire [ADDR_W:0]    wr_idx1;
    wire [DATA_W-1:0]  old0;
    wire [DATA_W-1:0]  old1;
    wire [DATA_W-1:0]  merged0;
    wire [DATA_W-1:0]  merged1;

    assign commit  = kn_rise & wr_act_ff;
    assign wr_idx0 = {wr_act_addr_ff, `DSP_WORD_FIRST};
    assign wr_idx1 = {wr_act_addr_ff, `DSP_WORD_SECOND};
    assign old0    = mem[wr_idx0];
    assign old1    = mem[wr_idx1];

    // per-lane merge, masked lanes keep stored bytes
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        assign merged0[l*`DSP_LANE_W +: `DSP_LANE_W] =
            wr_bsel0_n_ff[l] ? old0[l*`DSP_LANE_W +: `DSP_LANE_W]
                             : wr_word0_ff[l*`DSP_LANE_W +: `DSP_LANE_W];
        assign merged1[l*`DSP_LANE_W +: `DSP_LANE_W] =
            bsel_n_s[l] ? old1[l*`DSP_LANE_W +: `DSP_LANE_W]
                        : din_s[l*`DSP_LANE_W +: `DSP_LANE_W];
    end

    always_ff @(posedge core_clk) begin
        if (commit) begin
            mem[wr_idx0] <= merged0;
            mem[wr_idx1] <= merged1;
        end
    end

    // =================================================================
    // read pipeline, advanced on each true clock rising edge
    logic [LAST:0]      rd_pipe_ff;
    logic [ADDR_W-1:0]  rd_addr_ff [`DSP_RD_STAGES];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_pipe_ff <= '0;
        end else if (k_rise) begin
            rd_pipe_ff <= {rd_pipe_ff[LAST-1:0], rd_cmd};
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < `DSP_RD_STAGES; i++) begin
                rd_addr_ff[i] <= '0;
            end
        end else if (k_rise) begin
            rd_addr_ff[0] <= addr_s;
            for (int i = 1; i < `DSP_RD_STAGES; i++) begin
                rd_addr_ff[i] <= rd_addr_ff[i-1];
            end
        end
    end

    // array sampled on the same edge as any commit, so a write
    // issued after the read stays invisible to it
    wire               rd_start;
    wire [DATA_W-1:0]  rd_word0;
    wire [DATA_W-1:0]  rd_word1;

    assign rd_start = kn_rise & rd_pipe_ff[LAST];
    assign rd_word0 = mem[{rd_addr_ff[LAST], `DSP_WORD_FIRST}];
    assign rd_word1 = mem[{rd_addr_ff[LAST], `DSP_WORD_SECOND}];

    // =================================================================
    // read output phase
    dsp_rd_e            rd_ph_ff;
    dsp_rd_e            nxt_rd_ph;
    logic [DATA_W-1:0]  rd_hold_ff;

    always_comb begin
        nxt_rd_ph = rd_ph_ff;
        case (rd_ph_ff)
            DSP_RD_IDLE: begin
                if (rd_start) begin
                    nxt_rd_ph = DSP_RD_WORD0;
                end
            end
            DSP_RD_WORD0: begin
                if (k_rise) begin
                    nxt_rd_ph = DSP_RD_WORD1;
                end
            end
            DSP_RD_WORD1: begin
                if (rd_start) begin
                    nxt_rd_ph = DSP_RD_WORD0;
                end else if (kn_rise) begin
                    nxt_rd_ph = DSP_RD_IDLE;
                end
            end
            default: begin
                nxt_rd_ph = DSP_RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_ph_ff <= DSP_RD_IDLE;
        end else begin
            rd_ph_ff <= nxt_rd_ph;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_hold_ff <= '0;
        end else if (rd_start) begin
            rd_hold_ff <= rd_word1;
        end
    end

    // =================================================================
    // data bus drive
    logic [DATA_W-1:0]  dq_out_ff;
    logic               dq_oe_n_ff;
    logic               valid_ff;
    wire                load_word1;
    wire                drive_on;

    assign load_word1 = k_rise & (rd_ph_ff == DSP_RD_WORD0);
    assign drive_on   = (nxt_rd_ph != DSP_RD_IDLE);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dq_out_ff <= '0;
        end else if (rd_start) begin
            dq_out_ff <= rd_word0;
        end else if (load_word1) begin
            dq_out_ff <= rd_hold_ff;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dq_oe_n_ff <= `DSP_OE_N_RST;
            valid_ff   <= `DSP_VALID_RST;
        end else begin
            dq_oe_n_ff <= ~drive_on;
            valid_ff   <= drive_on;
        end
    end

    // =================================================================
    // echo clocks, same sampling delay as the data updates
    logic echo_p_ff;
    logic echo_n_ff;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            echo_p_ff <= `DSP_ECHO_P_RST;
            echo_n_ff <= `DSP_ECHO_N_RST;
        end else begin
            echo_p_ff <= k_s;
            echo_n_ff <= kn_s;
        end
    end

    // =================================================================
    // outputs
    assign dq_out          = dq_out_ff;
    assign dq_oe_n         = dq_oe_n_ff;
    assign read_valid_flag = valid_ff;
    assign echo_timing_p   = echo_p_ff;
    assign echo_timing_n   = echo_n_ff;

endmodule

// [src/dsp_defs.svh]
// Purpose: constants for the burst-of-two common-io memory port
// Assumes: included by its bare name
// Notes:   organisation defaults are the wide one
`ifndef DSP_DEFS_SVH
`define DSP_DEFS_SVH

// =====================================================================
// organisation
`define DSP_DATA_W       36
`define DSP_ADDR_W       19
`define DSP_LANE_W       9
`define DSP_BURST_LEN    2

// =====================================================================
// burst word positions
`define DSP_WORD_FIRST   1'b0
`define DSP_WORD_SECOND  1'b1

// =====================================================================
// read pipeline
`define DSP_RD_STAGES    3

// =====================================================================
// reset values
`define DSP_OE_N_RST     1'b1
`define DSP_VALID_RST    1'b0
`define DSP_ECHO_P_RST   1'b0
`define DSP_ECHO_N_RST   1'b1
`define DSP_BIT_RST      1'b0

`endif

// [src/dsp_pkg.sv]
// Purpose: types for the burst-of-two common-io memory port
// Assumes: nothing
// Notes:   read output phase is gray coded except the DSP_RD_WORD1 to DSP_RD_IDLE step
package dsp_pkg;

    // =================================================================
    // read output phase
    typedef enum logic [1:0] {
        DSP_RD_IDLE  = 2'b00,
        DSP_RD_WORD0 = 2'b01,
        DSP_RD_WORD1 = 2'b11
    } dsp_rd_e;

endpackage
